// ===== pllcs_pkg.sv
`default_nettype none
package pllcs_pkg;
	// Register port widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int DIV_W  = 11;
	localparam int HI_W   = 3;

	// Register offsets
	localparam logic [7:0] ADDR_DIV_LO = 8'h5c;
	localparam logic [7:0] ADDR_DIV_HI = 8'h5d;
	localparam logic [7:0] ADDR_CTL0   = 8'h5e;
	localparam logic [7:0] ADDR_CTL1   = 8'h5f;

	// Reset values and divider minimum
	localparam logic [7:0]  DIV_LO_RST = 8'h02;
	localparam logic [2:0]  DIV_HI_RST = 3'h0;
	localparam logic [7:0]  CTL0_RST   = 8'h00;
	localparam logic [10:0] DIV_MIN    = 11'h002;

	// Control register zero fields
	localparam int CP_LSB  = 6;
	localparam int LDS_LSB = 2;
	localparam int SRC_LSB = 0;

	// Control register one bits
	localparam int C1_LOCK_ST = 5;
	localparam int C1_ST_LOCK = 4;
	localparam int C1_ST_UNLK = 3;
	localparam int C1_EN_LOCK = 2;
	localparam int C1_EN_UNLK = 1;
	localparam int C1_ENABLE  = 0;

	// Clock source codes
	localparam logic [1:0] SRC_CRYSTAL_REFERENCE = 2'h0;
	localparam logic [1:0] SRC_LOOP = 2'h1;
	localparam logic [1:0] SRC_RTC  = 2'h2;
	localparam logic [1:0] SRC_KEEP = 2'h3;

	// Lock criteria timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int WIN_SHORT_NS  = 20;
	localparam int WIN_LONG_NS   = 400;
	localparam int WIN_SHORT_CYC = (WIN_SHORT_NS / CLK_PERIOD_NS < 1) ? 1 :
		WIN_SHORT_NS / CLK_PERIOD_NS;
	localparam int WIN_LONG_CYC  = (WIN_LONG_NS / CLK_PERIOD_NS < 1) ? 1 :
		WIN_LONG_NS / CLK_PERIOD_NS;
	localparam int RUN_FEW       = 8;
	localparam int RUN_MANY      = 16;
	localparam int ERR_W         = 6;
	localparam int RUN_W         = 5;

	typedef enum logic [1:0] {LD_IDLE, LD_HUNT, LD_LOCKED} pllcs_lock_t;
endpackage : pllcs_pkg
`default_nettype wire

// ===== pllcs_pfd_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pllcs_pfd_if;
	logic       refFall;
	logic       fbFall;
	logic       loopOn;
	logic [1:0] lockSel;
	logic       pumpUp;
	logic       pumpDown;
	logic       lockRaw;

	modport top (output refFall, output fbFall, output loopOn, output lockSel,
		input pumpUp, input pumpDown, input lockRaw);
	modport sub (input refFall, input fbFall, input loopOn, input lockSel,
		output pumpUp, output pumpDown, output lockRaw);
endinterface : pllcs_pfd_if
`default_nettype wire

// ===== pllcs_pfd_lock.sv
`timescale 1ns/100ps
`default_nettype none
module pllcs_pfd_lock
	import pllcs_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst,
	pllcs_pfd_if.sub  pfd
);
	////////////////////////////////////////////////////////////////////////
	// Phase comparator
	logic              upReg;
	logic              downReg;
	logic              upNext;
	logic              downNext;
	wire               upSeen   = upReg | pfd.refFall;
	wire               downSeen = downReg | pfd.fbFall;
	wire               bothSeen = upSeen & downSeen;

	assign upNext   = pfd.loopOn & upSeen & ~bothSeen;
	assign downNext = pfd.loopOn & downSeen & ~bothSeen;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			upReg   <= 1'b0;
			downReg <= 1'b0;
		end else begin
			upReg   <= upNext;
			downReg <= downNext;
		end
	end

	assign pfd.pumpUp   = upReg;
	assign pfd.pumpDown = downReg;

	////////////////////////////////////////////////////////////////////////
	// Lock detector
	logic [ERR_W-1:0] errCnt_reg;
	logic [RUN_W-1:0] runCnt_reg;
	pllcs_lock_t      state_reg;
	wire  [ERR_W-1:0] winCyc  = pfd.lockSel[1] ? ERR_W'(WIN_LONG_CYC) : ERR_W'(WIN_SHORT_CYC);
	wire  [RUN_W-1:0] runNeed = pfd.lockSel[0] ? RUN_W'(RUN_MANY) : RUN_W'(RUN_FEW);
	wire              errBad  = errCnt_reg >= winCyc;
	wire              goodCmp = bothSeen & ~errBad;
	wire  [RUN_W-1:0] runInc  = runCnt_reg + RUN_W'(1);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			errCnt_reg <= '0;
		end else if (!pfd.loopOn || bothSeen) begin
			errCnt_reg <= '0;
		end else if ((upSeen || downSeen) && !errBad) begin
			errCnt_reg <= errCnt_reg + ERR_W'(1);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			runCnt_reg <= '0;
			state_reg  <= LD_IDLE;
		end else begin
			case (state_reg)
				LD_IDLE: begin
					runCnt_reg <= '0;
					if (pfd.loopOn) state_reg <= LD_HUNT;
				end
				LD_HUNT: begin
					if (!pfd.loopOn) begin
						state_reg <= LD_IDLE;
					end else if (errBad) begin
						runCnt_reg <= '0;
					end else if (goodCmp) begin
						runCnt_reg <= runInc;
						if (runInc >= runNeed) state_reg <= LD_LOCKED;
					end
				end
				LD_LOCKED: begin
					if (!pfd.loopOn) begin
						state_reg <= LD_IDLE;
					end else if (errBad) begin
						runCnt_reg <= '0;
						state_reg  <= LD_HUNT;
					end
				end
				default: state_reg <= LD_IDLE;
			endcase
		end
	end

	assign pfd.lockRaw = (state_reg == LD_LOCKED);
endmodule : pllcs_pfd_lock
`default_nettype wire

// ===== pllcs_clock_ctrl.sv
// Behaviour
// - System clock equals reference times N
// - Comparator drives up/down from falling edges
// - Two-bit field picks four pump currents
// - Downcounter on oscillator divides by N
// - Loop source used only while locked
// - Lock after consecutive in-window reference cycles
// - Lock output high, can interrupt
// - Reset: loop off, crystal clocks system
// - High-byte write loads divider, minimum two
// - Criteria: 8/16 cycles, 20/400 ns
// - Source codes 00,01,10; 11 keeps
// - Sticky lock-gained/lost flags, separate enables
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pllcs_clock_ctrl
	import pllcs_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              refIn,
	input  wire logic              vcoIn,
	input  wire logic              rtcIn,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wrData,
	input  wire logic              wrStb,
	input  wire logic              rdStb,
	output logic      [DATA_W-1:0] rdData,
	output logic                   sysClkOut,
	output logic      [1:0]        activeSource,
	output logic      [1:0]        pumpCurrent,
	output logic                   pumpUp,
	output logic                   pumpDown,
	output logic                   loopEnable,
	output logic                   lockOut,
	output logic                   irq
);
	////////////////////////////////////////////////////////////////////////
	// Address decode
	wire selLo   = addr == ADDR_DIV_LO;
	wire selHi   = addr == ADDR_DIV_HI;
	wire selC0   = addr == ADDR_CTL0;
	wire selC1   = addr == ADDR_CTL1;
	wire wrLo    = wrStb & selLo;
	wire wrHi    = wrStb & selHi;
	wire wrC0    = wrStb & selC0;
	wire wrC1    = wrStb & selC1;
	wire rdC1    = rdStb & selC1;

	////////////////////////////////////////////////////////////////////////
	// Control registers
	logic [7:0]       divLo_reg;
	logic [DIV_W-1:0] divN_reg;
	logic [1:0]       cp_reg;
	logic [1:0]       lds_reg;
	logic [1:0]       srcReq_reg;
	logic             enLock_reg;
	logic             enUnlk_reg;
	logic             loopOn_reg;
	wire  [DIV_W-1:0] divRaw   = {wrData[HI_W-1:0], divLo_reg};
	wire  [DIV_W-1:0] divNext  = (divRaw < DIV_MIN) ? DIV_MIN : divRaw;
	wire              cfgOpen  = ~loopOn_reg;
	wire  [1:0]       srcWr    = wrData[SRC_LSB+1:SRC_LSB];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			divLo_reg <= DIV_LO_RST;
			divN_reg  <= {DIV_HI_RST, DIV_LO_RST};
		end else if (cfgOpen) begin
			if (wrLo) divLo_reg <= wrData;
			if (wrHi) divN_reg <= divNext;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cp_reg     <= CTL0_RST[CP_LSB+1:CP_LSB];
			lds_reg    <= CTL0_RST[LDS_LSB+1:LDS_LSB];
			srcReq_reg <= SRC_CRYSTAL_REFERENCE;
		end else if (wrC0) begin
			if (cfgOpen) begin
				cp_reg  <= wrData[CP_LSB+1:CP_LSB];
				lds_reg <= wrData[LDS_LSB+1:LDS_LSB];
			end
			if (srcWr != SRC_KEEP) srcReq_reg <= srcWr;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			enLock_reg <= 1'b0;
			enUnlk_reg <= 1'b0;
			loopOn_reg <= 1'b0;
		end else if (wrC1) begin
			enLock_reg <= wrData[C1_EN_LOCK];
			enUnlk_reg <= wrData[C1_EN_UNLK];
			loopOn_reg <= wrData[C1_ENABLE];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input edge detection
	logic refPrev_reg;
	logic vcoPrev_reg;
	wire  refFall = refPrev_reg & ~refIn;
	wire  vcoRise = ~vcoPrev_reg & vcoIn;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			refPrev_reg <= 1'b0;
			vcoPrev_reg <= 1'b0;
		end else begin
			refPrev_reg <= refIn;
			vcoPrev_reg <= vcoIn;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Feedback downcounter
	logic [DIV_W-1:0] divCnt_reg;
	logic             fb_reg;
	logic             fbPrev_reg;
	wire              cntLast = divCnt_reg <= DIV_W'(1);
	wire              fbHigh  = divCnt_reg > (divN_reg >> 1);
	wire              fbFall  = fbPrev_reg & ~fb_reg;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			divCnt_reg <= {DIV_HI_RST, DIV_LO_RST};
		end else if (!loopOn_reg) begin
			divCnt_reg <= divN_reg;
		end else if (vcoRise) begin
			divCnt_reg <= cntLast ? divN_reg : divCnt_reg - DIV_W'(1);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fb_reg     <= 1'b0;
			fbPrev_reg <= 1'b0;
		end else begin
			fb_reg     <= loopOn_reg & fbHigh;
			fbPrev_reg <= fb_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Phase comparator and lock detector
	pllcs_pfd_if pfdBus ();

	assign pfdBus.refFall = refFall;
	assign pfdBus.fbFall  = fbFall;
	assign pfdBus.loopOn  = loopOn_reg;
	assign pfdBus.lockSel = lds_reg;

	pllcs_pfd_lock uPfdLock (
		.mclk (mclk),
		.rst  (rst),
		.pfd  (pfdBus.sub)
	);

	////////////////////////////////////////////////////////////////////////
	// Lock synchroniser and edge flags
	logic lockMeta_reg;
	logic lockSync_reg;
	logic lockPrev_reg;
	logic stLock_reg;
	logic stUnlk_reg;
	wire  lockRise = lockSync_reg & ~lockPrev_reg;
	wire  lockFell = ~lockSync_reg & lockPrev_reg;
	wire  clrLock  = rdC1 | (wrC1 & wrData[C1_ST_LOCK]);
	wire  clrUnlk  = rdC1 | (wrC1 & wrData[C1_ST_UNLK]);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lockMeta_reg <= 1'b0;
			lockSync_reg <= 1'b0;
			lockPrev_reg <= 1'b0;
		end else begin
			lockMeta_reg <= pfdBus.lockRaw;
			lockSync_reg <= lockMeta_reg;
			lockPrev_reg <= lockSync_reg;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stLock_reg <= 1'b0;
			stUnlk_reg <= 1'b0;
		end else begin
			stLock_reg <= lockRise | (stLock_reg & ~clrLock);
			stUnlk_reg <= lockFell | (stUnlk_reg & ~clrUnlk);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock source switching
	logic [1:0] src_reg;
	logic       sysClk_reg;
	wire        loopOk    = loopOn_reg & lockSync_reg;
	wire  [1:0] srcWant   = (srcReq_reg == SRC_LOOP && !loopOk) ? SRC_CRYSTAL_REFERENCE : srcReq_reg;
	wire        wantLevel = (srcWant == SRC_LOOP) ? vcoIn :
		(srcWant == SRC_RTC) ? rtcIn : refIn;
	wire        curLevel  = (src_reg == SRC_LOOP) ? vcoIn :
		(src_reg == SRC_RTC) ? rtcIn : refIn;
	wire        swapOk    = ~sysClk_reg & ~wantLevel;
	wire        lostLoop  = (src_reg == SRC_LOOP) & ~loopOk;
	wire  [1:0] srcNext   = lostLoop ? SRC_CRYSTAL_REFERENCE :
		(srcWant != src_reg && swapOk) ? srcWant : src_reg;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			src_reg    <= SRC_CRYSTAL_REFERENCE;
			sysClk_reg <= 1'b0;
		end else begin
			src_reg    <= srcNext;
			sysClk_reg <= curLevel;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data and registered outputs
	wire [7:0] ctl0Rd = {cp_reg, 2'h0, lds_reg, srcReq_reg};
	wire [7:0] ctl1Rd = {2'h0, lockSync_reg, stLock_reg, stUnlk_reg,
		enLock_reg, enUnlk_reg, loopOn_reg};
	wire [7:0] rdMux  = selC0 ? ctl0Rd : selC1 ? ctl1Rd : 8'h00;
	wire       irqNext = (stLock_reg & enLock_reg) | (stUnlk_reg & enUnlk_reg);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdData <= 8'h00;
		end else if (rdStb) begin
			rdData <= rdMux;
		end else begin
			rdData <= 8'h00;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sysClkOut    <= 1'b0;
			activeSource <= SRC_CRYSTAL_REFERENCE;
			pumpCurrent  <= CTL0_RST[CP_LSB+1:CP_LSB];
			pumpUp       <= 1'b0;
			pumpDown     <= 1'b0;
			loopEnable   <= 1'b0;
			lockOut      <= 1'b0;
			irq          <= 1'b0;
		end else begin
			sysClkOut    <= sysClk_reg;
			activeSource <= src_reg;
			pumpCurrent  <= cp_reg;
			pumpUp       <= pfdBus.pumpUp;
			pumpDown     <= pfdBus.pumpDown;
			loopEnable   <= loopOn_reg;
			lockOut      <= lockSync_reg;
			irq          <= irqNext;
		end
	end
endmodule : pllcs_clock_ctrl
`default_nettype wire

// ===== pllcs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module pllcs_properties
	import pllcs_pkg::*;
(
	input wire logic              mclk,
	input wire logic              rst,
	input wire logic              refIn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              wrStb,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic              rdStb,
	input wire logic [DATA_W-1:0] rdData,
	input wire logic              sysClkOut,
	input wire logic [1:0]        activeSource,
	input wire logic [1:0]        pumpCurrent,
	input wire logic              loopEnable,
	input wire logic              lockOut,
	input wire logic              irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	logic       cpWrite;
	logic [2:0] xtalRun;

	assign cpWrite = wrStb && addr == ADDR_CTL0 && !loopEnable;

	// Cycles spent on the crystal source, saturating
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			xtalRun <= 3'h0;
		else if (activeSource != SRC_CRYSTAL_REFERENCE)
			xtalRun <= 3'h0;
		else if (xtalRun != 3'h4)
			xtalRun <= xtalRun + 3'h1;
	end

	////////////////////////
	a_rddata_idle: assert property (!$past(rdStb) |-> rdData == 8'h00)
		else $error("read data not zero outside read slot");
	a_divider_reads: assert property (rdStb && (addr == ADDR_DIV_LO ||
		addr == ADDR_DIV_HI) |=> rdData == 8'h00) else $error("divider read not zero");
	a_enable_write: assert property (wrStb && addr == ADDR_CTL1 && wrData[0]
		|-> ##2 loopEnable) else $error("loop enable not set by write");
	a_irq_masked: assert property (wrStb && addr == ADDR_CTL1 && wrData[2:1] == 2'h0
		|-> ##2 !irq) else $error("irq high with both enables off");
	a_pump_stable: assert property (!$stable(pumpCurrent)
		|-> $past(cpWrite) || $past(cpWrite, 2)) else $error("pump current changed unasked");
	a_source_locked: assert property (activeSource == SRC_LOOP |-> $past(lockOut)
		&& $past(loopEnable)) else $error("loop source without lock");
	a_sysclk_crystal_reference: assert property (xtalRun == 3'h4 |-> sysClkOut == $past(refIn, 2))
		else $error("system clock not following crystal");
	a_reset_crystal: assert property ($fell(rst) |-> activeSource == SRC_CRYSTAL_REFERENCE
		&& !loopEnable && !irq) else $error("reset state wrong");
	a_lock_enabled: assert property ($rose(lockOut) |-> loopEnable)
		else $error("lock without loop enabled");

	c_lock: cover property ($rose(lockOut));
	c_loop: cover property (activeSource == SRC_LOOP);
	c_irq: cover property ($rose(irq));
endmodule : pllcs_properties

bind pllcs_clock_ctrl pllcs_properties pllcs_properties_inst (.mclk(mclk), .rst(rst),
	.refIn(refIn), .addr(addr), .wrStb(wrStb), .wrData(wrData), .rdStb(rdStb),
	.rdData(rdData), .sysClkOut(sysClkOut), .activeSource(activeSource),
	.pumpCurrent(pumpCurrent), .loopEnable(loopEnable), .lockOut(lockOut), .irq(irq));
`default_nettype wire

// ===== pllcs_osc_model.sv
`timescale 1ns/100ps
`default_nettype none
module pllcs_osc_model (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic freeze,
	output logic      refIn,
	output logic      vcoIn,
	output logic      rtcIn
);
	logic [4:0] phase_reg;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			phase_reg <= 5'h0;
		else
			phase_reg <= phase_reg + 5'h1;
	end

	// Oscillator already on twice the reference; freeze stalls it
	assign refIn = phase_reg[2];
	assign vcoIn = phase_reg[1] & !freeze;
	assign rtcIn = phase_reg[4];
endmodule : pllcs_osc_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pllcs_pkg::*;
	logic       mclk, rst, refIn, vcoIn, rtcIn, wrStb, rdStb, freeze;
	logic       sysClkOut, pumpUp, pumpDown, loopEnable, lockOut, irq;
	logic [7:0] addr, wrData, rdData;
	logic [1:0] activeSource, pumpCurrent;
	int         mismatches, cmpCount;

	pllcs_clock_ctrl pllcs_clock_ctrl_inst (.mclk(mclk), .rst(rst), .refIn(refIn),
		.vcoIn(vcoIn), .rtcIn(rtcIn), .addr(addr), .wrData(wrData), .wrStb(wrStb),
		.rdStb(rdStb), .rdData(rdData), .sysClkOut(sysClkOut), .activeSource(activeSource),
		.pumpCurrent(pumpCurrent), .pumpUp(pumpUp), .pumpDown(pumpDown),
		.loopEnable(loopEnable), .lockOut(lockOut), .irq(irq));
	pllcs_osc_model pllcs_osc_model_inst (.mclk(mclk), .rst(rst), .freeze(freeze),
		.refIn(refIn), .vcoIn(vcoIn), .rtcIn(rtcIn));

	always #10 mclk = ~mclk;

	////////////////////////
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		cmpCount++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : settle

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		wrStb <= 1'b1;
		addr <= a;
		wrData <= d;
		@(posedge mclk);
		wrStb <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		rdStb <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rdStb <= 1'b0;
		#1;
		cmp(rdData, exp);
	endtask : rd

	task waitLock(input logic lvl);
		int n;
		n = 0;
		while (lockOut !== lvl && n < 600) begin
			settle(1);
			n++;
		end
		cmp({7'h0, lockOut}, {7'h0, lvl});
	endtask : waitLock

	task waitSrc(input logic [1:0] code);
		int n;
		n = 0;
		while (activeSource !== code && n < 400) begin
			settle(1);
			n++;
		end
		cmp({6'h0, activeSource}, {6'h0, code});
	endtask : waitSrc

	////////////////////////
	task tReset;
		rd(ADDR_CTL0, 8'h00);
		rd(ADDR_CTL1, 8'h00);
		rd(ADDR_DIV_LO, 8'h00);
		rd(8'h60, 8'h00);
		cmp({6'h0, activeSource}, {6'h0, SRC_CRYSTAL_REFERENCE});
		cmp({6'h0, pumpUp, pumpDown}, 8'h00);
	endtask : tReset

	task tConfig;
		logic [1:0] c;
		wr(ADDR_DIV_LO, 8'h01);
		wr(ADDR_DIV_HI, 8'hf8);
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			wr(ADDR_CTL0, {c, 2'h3, c, 2'h0});
			settle(2);
			cmp({6'h0, pumpCurrent}, {6'h0, c});
			rd(ADDR_CTL0, {c, 2'h0, c, 2'h0});
		end
	endtask : tConfig

	task tLock;
		wr(ADDR_CTL1, 8'h05);
		settle(1);
		cmp({7'h0, loopEnable}, 8'h01);
		wr(ADDR_CTL0, 8'h00);
		rd(ADDR_CTL0, 8'hcc);
		waitLock(1'b1);
		settle(3);
		cmp({7'h0, irq}, 8'h01);
		rd(ADDR_CTL1, 8'h35);
		settle(3);
		cmp({7'h0, irq}, 8'h00);
		rd(ADDR_CTL1, 8'h25);
	endtask : tLock

	task tSwitch;
		wr(ADDR_CTL0, 8'h01);
		waitSrc(SRC_LOOP);
		wr(ADDR_CTL0, 8'h03);
		rd(ADDR_CTL0, 8'hcd);
		cmp({6'h0, activeSource}, {6'h0, SRC_LOOP});
	endtask : tSwitch

	task tUnlock;
		@(posedge mclk);
		freeze <= 1'b1;
		waitLock(1'b0);
		settle(1);
		cmp({6'h0, activeSource}, {6'h0, SRC_CRYSTAL_REFERENCE});
		cmp({6'h0, pumpUp, pumpDown}, 8'h02);
		cmp({7'h0, irq}, 8'h00);
		rd(ADDR_CTL1, 8'h0d);
		rd(ADDR_CTL1, 8'h05);
		freeze <= 1'b0;
	endtask : tUnlock

	task tRtc;
		waitLock(1'b1);
		wr(ADDR_CTL1, 8'h15);
		rd(ADDR_CTL1, 8'h25);
		cmp({7'h0, irq}, 8'h00);
		wr(ADDR_CTL0, 8'h02);
		waitSrc(SRC_RTC);
		wr(ADDR_CTL0, 8'h00);
		waitSrc(SRC_CRYSTAL_REFERENCE);
		wr(ADDR_CTL1, 8'h00);
	endtask : tRtc

	task summarize;
		$display("comparisons %0d mismatches %0d", cmpCount, mismatches);
		if (mismatches == 0 && cmpCount > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	initial begin
		#100000;
		mismatches++;
		summarize();
	end

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		addr = 8'h00;
		wrData = 8'h00;
		wrStb = 1'b0;
		rdStb = 1'b0;
		freeze = 1'b0;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		tReset();
		tConfig();
		tLock();
		tSwitch();
		tUnlock();
		tRtc();
		summarize();
	end
endmodule : testbench
`default_nettype wire
